// ===== core/dflec_link_error_control.sv
// deframer link error control: config registers, lane error
// counters, sync request generation, checksum, test pattern check
// assumes lane error strobes and ilas octets come from logic on clk
`timescale 1ns/1ps
module dflec_link_error_control
  import dflec_pkg::*;
(
  input  wire logic                              clk,
  input  wire logic                              reset,
  input  wire logic [dflec_pkg::ADDR_W-1:0]      regAddr,
  input  wire logic [7:0]                        regWrData,
  input  wire logic                              regWr,
  input  wire logic                              regRd,
  output logic      [7:0]                        regRdData,
  input  wire logic [dflec_pkg::NUM_LANES-1:0]   badDisparityError,
  input  wire logic [dflec_pkg::NUM_LANES-1:0]   tableMissError,
  input  wire logic [dflec_pkg::NUM_LANES-1:0]   unexpectedCtrlCharError,
  input  wire logic [13:0][7:0]                  ilasConfigOctets,
  input  wire logic                              ilasConfigValid,
  input  wire logic [7:0]                        rxTestData,
  input  wire logic                              rxTestDataValid,
  output logic                                   syncRequestOut,
  output logic                                   irq,
  output logic                                   deframerEnable,
  output logic                                   perpetualAlignmentMode,
  output logic                                   repetitiveTestActive,
  output logic      [7:0]                        alignmentMultiframeCount,
  output logic      [7:0]                        checksumValue,
  output logic                                   checksumMismatch
);
  import dflec_pkg::*;

  typedef struct packed {
    logic                             deframer_soft_reset;
    logic                             dfEna;
    logic                             cksumSel;
    logic                             perpAlign;
    logic                             repData;
    logic                             repActive;
    logic                             queueMode;
    logic                             autoClr;
    logic [7:0]                       mfCount;
    logic [7:0]                       thres;
    logic [2:0]                       syncMask;
    logic [NUM_LANES-1:0][2:0]        laneEna;
    logic [7:0]                       testPat;
    logic [4:0]                       irqStat;
    logic [4:0]                       irqMask;
    logic [NUM_LANES-1:0][2:0][7:0]   cnt;
    logic [4:0]                       queueCnt;
    logic [2:0]                       syncTimer;
    logic                             sync_request_out;
    logic                             irqOut;
    logic [7:0]                       rdData;
    logic [7:0]                       cksum;
    logic                             cksumBad;
  } dflec_state_s;

  dflec_state_s                        s_reg;
  dflec_state_s                        s_next;
  logic [NUM_LANES-1:0][2:0]           errIn;
  logic [NUM_LANES-1:0][2:0]           hit;
  logic [NUM_LANES-1:0][2:0]           syncHit;
  logic [7:0]                          incVal;
  logic [4:0]                          qSum;

  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  // mask bit order is reversed against counter order
  function automatic logic maskFor(input logic [2:0] m, input int t);
    maskFor = m[2-t];
  endfunction

  function automatic logic [4:0] countHits(
      input logic [NUM_LANES-1:0][2:0] h);
    logic [4:0] c;
    c = 5'h00;
    for (int l = 0; l < NUM_LANES; l++) begin
      for (int t = 0; t < NUM_ERR; t++) begin
        c = c + {4'h0, h[l][t]};
      end
    end
    countHits = c;
  endfunction

  function automatic logic [7:0] fieldSum(input logic [13:0][7:0] o);
    logic [7:0] f;
    f = o[0];
    f = f + {4'h0, o[1][3:0]} + {4'h0, o[1][7:4]};
    f = f + {7'h00, o[2][6]} + {7'h00, o[2][5]};
    f = f + {3'h0, o[2][4:0]} + {7'h00, o[3][7]};
    f = f + {3'h0, o[3][4:0]} + o[4] + {3'h0, o[5][4:0]};
    f = f + o[6] + {6'h00, o[7][7:6]} + {3'h0, o[7][4:0]};
    f = f + {5'h00, o[8][7:5]} + {3'h0, o[8][4:0]};
    f = f + {5'h00, o[9][7:5]} + {3'h0, o[9][4:0]};
    f = f + {7'h00, o[10][7]} + {3'h0, o[10][4:0]};
    fieldSum = f;
  endfunction

  function automatic logic [7:0] byteSum(input logic [13:0][7:0] o);
    logic [7:0] b;
    b = 8'h00;
    for (int i = 0; i < 13; i++) begin
      b = b + o[i];
    end
    byteSum = b;
  endfunction

  function automatic logic [11:0] laneOfs(input int l);
    laneOfs = OFS_LANE_CTRL0 + 12'(l);
  endfunction

  // ----------------------------------------------------------
  // lane error vectors, counter order bde, nit, uek
  // ----------------------------------------------------------
  always_comb begin
    for (int l = 0; l < NUM_LANES; l++) begin
      errIn[l][ERR_BDE] = badDisparityError[l];
      errIn[l][ERR_NIT] = tableMissError[l];
      errIn[l][ERR_UEK] = unexpectedCtrlCharError[l];
    end
  end

  // ----------------------------------------------------------
  // next state
  // ----------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.rdData = 8'h00;
    hit = '0;
    syncHit = '0;
    incVal = 8'h00;
    qSum = 5'h00;

    // register writes; settings are expected only in soft reset
    if (regWr) begin
      case (regAddr)
        OFS_SOFT_RESET: begin
          s_next.deframer_soft_reset = regWrData[SOFT_RST_BIT];
        end
        OFS_CKSUM_CTRL: begin
          s_next.cksumSel = regWrData[CKSUM_SEL_BIT];
        end
        OFS_LINK_TEST: begin
          s_next.perpAlign = regWrData[PERP_ALIGN_BIT];
          s_next.repData   = regWrData[REP_DATA_BIT];
          s_next.queueMode = regWrData[QUEUE_ERR_BIT];
          s_next.autoClr   = regWrData[AUTO_CLR_BIT];
        end
        OFS_MF_COUNT: begin
          // invalid counts are dropped, the old value stays
          if (regWrData == 8'h01 || regWrData == 8'h02 ||
              regWrData == 8'h04) begin
            s_next.mfCount = regWrData;
          end
        end
        OFS_ERR_THRES: begin
          s_next.thres = regWrData;
        end
        OFS_SYNC_MASK: begin
          s_next.syncMask = regWrData[2:0];
        end
        OFS_TEST_PAT: begin
          s_next.testPat = regWrData;
        end
        OFS_IRQ_MASK: begin
          s_next.irqMask = regWrData[4:0];
        end
        default: begin
          for (int l = 0; l < NUM_LANES; l++) begin
            if (regAddr == laneOfs(l)) begin
              s_next.laneEna[l] = regWrData[5:3];
            end
          end
        end
      endcase
    end
    // pattern test is only armed with perpetual alignment off
    s_next.repActive = s_next.repData & ~s_next.perpAlign;

    // register reads, data shows one cycle later
    if (regRd) begin
      case (regAddr)
        OFS_SOFT_RESET: s_next.rdData = {4'h0, s_reg.deframer_soft_reset, 3'h0};
        OFS_CKSUM_CTRL: s_next.rdData = {7'h00, s_reg.cksumSel};
        OFS_LINK_TEST: begin
          s_next.rdData = {s_reg.perpAlign, 1'b0, s_reg.repData,
                           s_reg.queueMode, s_reg.autoClr,
                           3'h0};
        end
        OFS_MF_COUNT:   s_next.rdData = s_reg.mfCount;
        OFS_ERR_THRES:  s_next.rdData = s_reg.thres;
        OFS_SYNC_MASK:  s_next.rdData = {5'h00, s_reg.syncMask};
        OFS_TEST_PAT:   s_next.rdData = s_reg.testPat;
        OFS_IRQ_STATUS: begin
          s_next.rdData  = {3'h0, s_reg.irqStat};
          s_next.irqStat = 5'h00;
        end
        OFS_IRQ_MASK:   s_next.rdData = {3'h0, s_reg.irqMask};
        default: begin
          for (int l = 0; l < NUM_LANES; l++) begin
            if (regAddr == laneOfs(l)) begin
              s_next.rdData = {2'h0, s_reg.laneEna[l], 3'h0};
            end
          end
        end
      endcase
    end

    // --------------------------------------------------------
    // error counters
    // --------------------------------------------------------
    // a counter parked at the threshold stops, so it cannot wrap
    // and fire a second time without being cleared
    for (int l = 0; l < NUM_LANES; l++) begin
      for (int t = 0; t < NUM_ERR; t++) begin
        if (!s_reg.deframer_soft_reset && errIn[l][t] && s_reg.laneEna[l][t] &&
            s_reg.cnt[l][t] != s_reg.thres) begin
          incVal = s_reg.cnt[l][t] + 8'h01;
          s_next.cnt[l][t] = incVal;
          hit[l][t] = (incVal == s_reg.thres);
          syncHit[l][t] = hit[l][t] &&
                          maskFor(s_reg.syncMask, t);
          if (syncHit[l][t] && s_reg.autoClr) begin
            s_next.cnt[l][t] = 8'h00;
          end
        end
      end
    end

    // --------------------------------------------------------
    // sync request
    // --------------------------------------------------------
    if (s_reg.syncTimer != 3'h0) begin
      s_next.syncTimer = s_reg.syncTimer - 3'h1;
    end
    if (s_reg.queueMode) begin
      // hits wait in the queue, one assertion each
      qSum = s_reg.queueCnt;
      if (s_reg.syncTimer == 3'h0 && qSum != 5'h00) begin
        s_next.syncTimer = SYNC_TOTAL_CYC;
        qSum = qSum - 5'h01;
      end
      if (countHits(syncHit) > QUEUE_MAX - qSum) begin
        s_next.queueCnt = QUEUE_MAX;
      end else begin
        s_next.queueCnt = qSum + countHits(syncHit);
      end
    end else if (s_reg.syncTimer == 3'h0 && |syncHit) begin
      // any number of lanes in one cycle is one report
      s_next.syncTimer = SYNC_TOTAL_CYC;
    end

    // --------------------------------------------------------
    // checksum and pattern check
    // --------------------------------------------------------
    if (!s_reg.deframer_soft_reset && ilasConfigValid) begin
      if (s_reg.cksumSel) begin
        s_next.cksum = byteSum(ilasConfigOctets);
      end else begin
        s_next.cksum = fieldSum(ilasConfigOctets);
      end
      s_next.cksumBad = (s_next.cksum != ilasConfigOctets[13]);
    end

    // status sets land after a read clear, so set wins
    for (int t = 0; t < NUM_ERR; t++) begin
      for (int l = 0; l < NUM_LANES; l++) begin
        if (hit[l][t]) begin
          s_next.irqStat[t] = 1'b1;
        end
      end
    end
    if (!s_reg.deframer_soft_reset && ilasConfigValid && s_next.cksumBad) begin
      s_next.irqStat[ST_CKSUM] = 1'b1;
    end
    if (!s_reg.deframer_soft_reset && s_reg.repActive && rxTestDataValid &&
        rxTestData != s_reg.testPat) begin
      s_next.irqStat[ST_PAT] = 1'b1;
    end

    // soft reset clears counters, sync queue, sync timer and checksum; irq status is kept
    if (s_reg.deframer_soft_reset) begin
      s_next.cnt = '0;
      s_next.queueCnt = 5'h00;
      s_next.syncTimer = 3'h0;
      s_next.cksum = 8'h00;
      s_next.cksumBad = 1'b0;
    end
    s_next.sync_request_out = (s_next.syncTimer > SYNC_GAP_CYC);
    s_next.irqOut = |(s_next.irqStat & s_next.irqMask);
    s_next.dfEna = ~s_next.deframer_soft_reset;
  end

  // ----------------------------------------------------------
  // state register
  // ----------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      s_reg <= '0;
      s_reg.dfEna <= 1'b1;
      s_reg.mfCount <= MF_COUNT_RST;
      s_reg.thres <= ERR_THRES_RST;
      s_reg.syncMask <= SYNC_MASK_RST;
      s_reg.laneEna <= {NUM_LANES{LANE_ENA_RST}};
      s_reg.testPat <= TEST_PAT_RST;
      s_reg.irqMask <= IRQ_MASK_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign regRdData                = s_reg.rdData;
  assign syncRequestOut           = s_reg.sync_request_out;
  assign irq                      = s_reg.irqOut;
  assign deframerEnable           = s_reg.dfEna;
  assign perpetualAlignmentMode   = s_reg.perpAlign;
  assign repetitiveTestActive     = s_reg.repActive;
  assign alignmentMultiframeCount = s_reg.mfCount;
  assign checksumValue            = s_reg.cksum;
  assign checksumMismatch         = s_reg.cksumBad;
endmodule

// ===== core/dflec_pkg.sv
// constants for the deframer link error control block
// assumes an 8-bit register port with 12-bit byte addresses
package dflec_pkg;
  localparam int          NUM_LANES = 4;
  localparam int          NUM_ERR   = 3;
  localparam int          ADDR_W    = 12;
  // --------------------------------------------------------
  // register offsets
  // --------------------------------------------------------
  localparam logic [11:0] OFS_SOFT_RESET = 12'h475;
  localparam logic [11:0] OFS_CKSUM_CTRL = 12'h476;
  localparam logic [11:0] OFS_LINK_TEST  = 12'h477;
  localparam logic [11:0] OFS_MF_COUNT   = 12'h478;
  localparam logic [11:0] OFS_ERR_THRES  = 12'h47c;
  localparam logic [11:0] OFS_SYNC_MASK  = 12'h47d;
  localparam logic [11:0] OFS_LANE_CTRL0 = 12'h480;
  localparam logic [11:0] OFS_TEST_PAT   = 12'h490;
  localparam logic [11:0] OFS_IRQ_STATUS = 12'h491;
  localparam logic [11:0] OFS_IRQ_MASK   = 12'h492;
  // --------------------------------------------------------
  // field positions
  // --------------------------------------------------------
  localparam int SOFT_RST_BIT   = 3;
  localparam int CKSUM_SEL_BIT  = 0;
  localparam int PERP_ALIGN_BIT = 7;
  localparam int REP_DATA_BIT   = 5;
  localparam int QUEUE_ERR_BIT  = 4;
  localparam int AUTO_CLR_BIT   = 3;
  localparam int LANE_ENA_LSB   = 3;
  // error type index inside counters and enables
  localparam int ERR_BDE = 0;
  localparam int ERR_NIT = 1;
  localparam int ERR_UEK = 2;
  // status bits
  localparam int ST_CKSUM = 3;
  localparam int ST_PAT   = 4;
  // --------------------------------------------------------
  // reset values
  // --------------------------------------------------------
  localparam logic [7:0] MF_COUNT_RST  = 8'h01;
  localparam logic [7:0] ERR_THRES_RST = 8'hff;
  localparam logic [2:0] SYNC_MASK_RST = 3'h7;
  localparam logic [2:0] LANE_ENA_RST  = 3'h7;
  localparam logic [4:0] IRQ_MASK_RST  = 5'h00;
  localparam logic [7:0] TEST_PAT_RST  = 8'h00;
  // --------------------------------------------------------
  // sync request timing, cycles
  // --------------------------------------------------------
  localparam logic [2:0] SYNC_ASSERT_CYC = 3'h4;
  localparam logic [2:0] SYNC_GAP_CYC    = 3'h2;
  localparam logic [2:0] SYNC_TOTAL_CYC  = SYNC_ASSERT_CYC
                                           + SYNC_GAP_CYC;
  localparam logic [4:0] QUEUE_MAX       = 5'h1f;
endpackage

// ===== tb/dflec_link_error_control_monitor.sv
// concurrent checks on the link error control block ports
// assumes it is bound to the block top and sees its ports only
`timescale 1ns/1ps
module dflec_lec_monitor
  import dflec_pkg::*;
(
  input  wire logic                         clk,
  input  wire logic                         reset,
  input  wire logic                         regRd,
  input  wire logic [dflec_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [7:0]                   regRdData,
  input  wire logic                         ilasConfigValid,
  input  wire logic                         syncRequestOut,
  input  wire logic                         deframerEnable,
  input  wire logic                         perpetualAlignmentMode,
  input  wire logic                         repetitiveTestActive,
  input  wire logic [7:0]                   alignmentMultiframeCount,
  input  wire logic [7:0]                   checksumValue
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // ----------------------------------------------------------
  // sync request shape and cause
  // ----------------------------------------------------------
  sync_len_a: assert property (
    $rose(syncRequestOut) |-> syncRequestOut [*4] ##1 !syncRequestOut
  ) else $error("sync request length wrong");
  sync_gap_a: assert property (
    $fell(syncRequestOut) |-> !syncRequestOut [*2]
  ) else $error("sync request gap too short");
  // one cycle of slack: the sync request clears one cycle after the enable output falls
  sync_soft_a: assert property (
    !deframerEnable && !$past(deframerEnable) |-> !syncRequestOut
  ) else $error("sync request during soft reset");
  // ----------------------------------------------------------
  // register side
  // ----------------------------------------------------------
  rd_idle_a: assert property (
    !$past(regRd) |-> regRdData == 8'h00
  ) else $error("read data outside read cycle");
  reserved_zero_a: assert property (
    $past(regRd) && $past(regAddr) == OFS_SYNC_MASK
    |-> regRdData[7:3] == 5'h00
  ) else $error("reserved mask bits not zero");
  test_excl_a: assert property (
    repetitiveTestActive |-> !perpetualAlignmentMode
  ) else $error("pattern test with alignment mode");
  mf_legal_a: assert property (
    alignmentMultiframeCount inside {8'h01, 8'h02, 8'h04}
  ) else $error("illegal multiframe count");
  cksum_cause_a: assert property (
    $changed(checksumValue)
    |-> $past(ilasConfigValid) || !$past(deframerEnable)
  ) else $error("checksum changed without config");
endmodule
bind dflec_link_error_control dflec_lec_monitor mon (
  .clk, .reset, .regRd, .regAddr, .regRdData, .ilasConfigValid,
  .syncRequestOut, .deframerEnable, .perpetualAlignmentMode,
  .repetitiveTestActive, .alignmentMultiframeCount, .checksumValue
);

// ===== tb/dflec_far_framer.sv
// far-end transmit framer model: lane errors, config octets, test data
// assumes the bench pulses ilasGo and testGo for one cycle and holds errGo for two
`timescale 1ns/1ps
module dflec_far_framer
  import dflec_pkg::*;
(
  input  wire logic                            clk,
  input  wire logic                            errGo,
  input  wire logic [2:0]                      errKind,
  input  wire logic [dflec_pkg::NUM_LANES-1:0] errLanes,
  input  wire logic                            ilasGo,
  input  wire logic                            ilasBad,
  input  wire logic                            testGo,
  input  wire logic [7:0]                      testByte,
  output logic      [dflec_pkg::NUM_LANES-1:0] bde,
  output logic      [dflec_pkg::NUM_LANES-1:0] table_miss_error,
  output logic      [dflec_pkg::NUM_LANES-1:0] unexpected_control_char_error,
  output logic      [13:0][7:0]                octets,
  output logic                                 octValid,
  output logic      [7:0]                      testData,
  output logic                                 testValid
);
  logic [7:0] sum;
  always_comb begin
    sum = 8'h00;
    for (int i = 0; i < 13; i++) begin
      sum = sum + 8'(i * 17);
    end
  end
  initial begin
    octets = '0;
    testData = 8'h00;
  end
  always @(posedge clk) begin
    bde <= (errGo && errKind[ERR_BDE]) ? errLanes : '0;
    table_miss_error <= (errGo && errKind[ERR_NIT]) ? errLanes : '0;
    unexpected_control_char_error <= (errGo && errKind[ERR_UEK]) ? errLanes : '0;
    octValid <= ilasGo;
    testValid <= testGo;
    // idle data toggles so a stale value never passes for a match
    testData <= testGo ? testByte : ~testData;
    if (ilasGo) begin
      for (int i = 0; i < 13; i++) begin
        octets[i] <= 8'(i * 17);
      end
      octets[13] <= sum ^ {8{ilasBad}};
    end else begin
      octets <= ~octets;
    end
  end
endmodule

// ===== tb/tb_top.sv
// self-checking bench for the link error control block
// assumes the far framer model drives every lane-side input
`timescale 1ns/1ps
module tb_top;
  import dflec_pkg::*;
  logic [ADDR_W-1:0]    regAddr = '0;
  logic [7:0]           regWrData = '0;
  logic                 clk = 1'b0;
  logic                 reset = 1'b1;
  logic                 regWr = 1'b0;
  logic                 regRd = 1'b0;
  logic                 errGo = 1'b0;
  logic                 ilasGo = 1'b0;
  logic                 ilasBad = 1'b0;
  logic                 testGo = 1'b0;
  logic [2:0]           errKind = '0;
  logic [NUM_LANES-1:0] errLanes = '0;
  logic [NUM_LANES-1:0] bde, table_miss_error, unexpected_control_char_error;
  logic [7:0]           testByte = '0;
  logic [7:0]           regRdData, checksumValue, testData, sum;
  logic [7:0]           alignmentMultiframeCount;
  logic [13:0][7:0]     octets;
  logic                 octValid, testValid, syncRequestOut, irq;
  logic                 deframerEnable, perpetualAlignmentMode;
  logic                 repetitiveTestActive, checksumMismatch;
  logic                 syncPrev = 1'b0;
  int                   error_cnt = 0;
  int                   num_checks = 0;
  int                   rises = 0;
  always #5 clk = ~clk;
  always @(negedge clk) begin
    syncPrev <= syncRequestOut;
    if (syncRequestOut && !syncPrev) begin
      rises <= rises + 1;
    end
  end
  dflec_far_framer far (.clk, .errGo, .errKind, .errLanes, .ilasGo,
    .ilasBad, .testGo, .testByte, .bde, .table_miss_error, .unexpected_control_char_error, .octets, .octValid,
    .testData, .testValid);
  dflec_link_error_control uut (.clk, .reset, .regAddr, .regWrData,
    .regWr, .regRd, .regRdData, .badDisparityError(bde),
    .tableMissError(table_miss_error), .unexpectedCtrlCharError(unexpected_control_char_error),
    .ilasConfigOctets(octets), .ilasConfigValid(octValid),
    .rxTestData(testData), .rxTestDataValid(testValid), .syncRequestOut,
    .irq, .deframerEnable, .perpetualAlignmentMode, .repetitiveTestActive,
    .alignmentMultiframeCount, .checksumValue, .checksumMismatch);
  // ----------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------
  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic flag(input string n, input logic e, ref logic s);
    @(negedge clk);
    chk(n, {7'h0, e}, {7'h0, s});
    @(posedge clk);
  endtask
  // the extra edge keeps a strobe from being lowered and raised at once
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    chk("read data", e, regRdData);
    @(posedge clk);
  endtask
  // two errors per hit, so a threshold of 2 is reached exactly
  task automatic hit(input logic [2:0] k, input logic [3:0] l,
                     input int e);
    int r0;
    r0 = rises;
    errKind <= k;
    errLanes <= l;
    errGo <= 1'b1;
    repeat (2) @(posedge clk);
    errGo <= 1'b0;
    repeat (40) @(posedge clk);
    chk("sync pulses", 8'(e), 8'(rises - r0));
  endtask
  task automatic send(input logic b, input logic [7:0] t,
                      input logic [7:0] ck, input logic [7:0] st);
    ilasBad <= b;
    testByte <= t;
    ilasGo <= 1'b1;
    testGo <= 1'b1;
    @(posedge clk);
    ilasGo <= 1'b0;
    testGo <= 1'b0;
    repeat (3) @(negedge clk);
    chk("checksum", ck, checksumValue);
    chk("mismatch", {7'h0, b}, {7'h0, checksumMismatch});
    @(posedge clk);
    rd(OFS_IRQ_STATUS, st);
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    close_out();
  end
  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  initial begin
    sum = 8'h00;
    for (int i = 0; i < 13; i++) begin
      sum = sum + 8'(i * 17);
    end
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rd(OFS_MF_COUNT, 8'h01);
    rd(OFS_ERR_THRES, 8'hff);
    rd(OFS_SYNC_MASK, 8'h07);
    rd(OFS_LINK_TEST, 8'h00);
    rd(OFS_LANE_CTRL0, 8'h38);
    rd(12'h4ff, 8'h00);
    wr(OFS_SOFT_RESET, 8'h08);
    flag("enable", 1'b0, deframerEnable);
    hit(3'h1, 4'hf, 0);
    wr(OFS_ERR_THRES, 8'h02);
    wr(OFS_MF_COUNT, 8'h03);
    rd(OFS_MF_COUNT, 8'h01);
    wr(OFS_MF_COUNT, 8'h04);
    rd(OFS_MF_COUNT, 8'h04);
    chk("mf count", 8'h04, alignmentMultiframeCount);
    wr(OFS_LINK_TEST, 8'hff);
    rd(OFS_LINK_TEST, 8'hb8);
    flag("perpetual", 1'b1, perpetualAlignmentMode);
    flag("rep test", 1'b0, repetitiveTestActive);
    wr(OFS_LINK_TEST, 8'h00);
    wr(OFS_IRQ_MASK, 8'h1f);
    wr(OFS_SOFT_RESET, 8'h00);
    hit(3'h1, 4'hf, 1);
    flag("irq", 1'b1, irq);
    hit(3'h1, 4'hf, 0);
    rd(OFS_IRQ_STATUS, 8'h01);
    flag("irq", 1'b0, irq);
    wr(OFS_SOFT_RESET, 8'h08);
    wr(OFS_SYNC_MASK, 8'hfb);
    rd(OFS_SYNC_MASK, 8'h03);
    wr(OFS_SOFT_RESET, 8'h00);
    for (int k = 0; k < 3; k++) begin
      hit(3'(1 << k), 4'h2, (k == 0) ? 0 : 1);
    end
    rd(OFS_IRQ_STATUS, 8'h07);
    wr(OFS_SOFT_RESET, 8'h08);
    wr(OFS_SYNC_MASK, 8'h07);
    wr(OFS_LINK_TEST, 8'h18);
    wr(OFS_SOFT_RESET, 8'h00);
    hit(3'h1, 4'h3, 2);
    hit(3'h1, 4'h1, 1);
    rd(OFS_IRQ_STATUS, 8'h01);
    wr(OFS_SOFT_RESET, 8'h08);
    wr(OFS_CKSUM_CTRL, 8'h01);
    wr(OFS_LINK_TEST, 8'h20);
    wr(OFS_TEST_PAT, 8'h5a);
    wr(OFS_LANE_CTRL0 + 12'h001, 8'h30);
    rd(OFS_LANE_CTRL0 + 12'h001, 8'h30);
    wr(OFS_SOFT_RESET, 8'h00);
    // lane 1 disparity counting is off, so no pulse may follow
    hit(3'h1, 4'h2, 0);
    flag("rep test", 1'b1, repetitiveTestActive);
    send(1'b0, 8'h5a, sum, 8'h00);
    send(1'b1, 8'h5b, sum, 8'h18);
    wr(OFS_SOFT_RESET, 8'h08);
    wr(OFS_CKSUM_CTRL, 8'h00);
    wr(OFS_SOFT_RESET, 8'h00);
    // field sum of the model's octets differs from the byte sum
    send(1'b1, 8'h5a, 8'h23, 8'h08);
    close_out();
  end
endmodule
